// File: hdl/gtg_regs.vh
// register offsets, fields, reset values and timing for the tone generator
`ifndef GTG_REGS_VH
`define GTG_REGS_VH
`define GTG_ADDR_AMPL      4'h0
`define GTG_ADDR_FREQ      4'h4
`define GTG_ADDR_DECAY     4'h8
`define GTG_ADDR_PRESC     4'hc
`define GTG_ACTIVE_BIT     7
`define GTG_MCA_BIT        7
`define GTG_RATE_MSB       2
`define GTG_FREQ_MSB       6
`define GTG_PRESC_RST      8'hff
`define GTG_FREQ_RST       7'h00
`define GTG_RATE_RST       3'h0
`define GTG_RATE_MAX       3'h5
`define GTG_AMP_W          13
`define GTG_DECAY_SHIFT    5
`endif

// File: hdl/gtg_divider.v
// programmable divider producing a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module gtg_divider #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk,
  input  wire         rstn,
  // control
  input  wire         run,
  input  wire         restart,
  input  wire [W-1:0] div,
  // output
  output reg          tick
);
  reg [W-1:0] cnt_ff;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= {W{1'b0}};
      tick   <= 1'b0;
    end else if (!run || restart) begin
      cnt_ff <= {W{1'b0}};
      tick   <= 1'b0;
    end else if (cnt_ff >= div) begin
      // divide by div plus one; compare handles a shrunk divider
      cnt_ff <= {W{1'b0}};
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      tick   <= 1'b0;
    end
  end
endmodule // gtg_divider
`default_nettype wire

// File: hdl/gtg_pwm.v
// pwm slice: high for amplitude plus one trigger periods of each window
`timescale 1ns/1ps
`default_nettype none
module gtg_pwm (
  // clock and reset
  input  wire       clk,
  input  wire       rstn,
  // control
  input  wire       run,
  input  wire       restart,
  input  wire       trig,
  input  wire [7:0] level,
  input  wire [7:0] presc,
  // output
  output reg        pwm
);
  reg [7:0] ph_ff;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_ff <= 8'h00;
      pwm   <= 1'b0;
    end else if (!run || restart) begin
      ph_ff <= 8'h00;
      pwm   <= 1'b0;
    end else begin
      if (trig)
        ph_ff <= (ph_ff >= presc) ? 8'h00 : ph_ff + 8'h01;
      // saturates when level is at or above presc
      pwm <= (ph_ff <= level);
    end
  end
endmodule // gtg_pwm
`default_nettype wire

// File: hdl/gtg_tone_generator.v
// tone generator top: wishbone registers, tone and decay engine
// Contract
// RQ1 - any amplitude write starts or stops tone
// RQ2 - writing zero stops tone, clears active
// RQ3 - nonzero write restarts tone at once
// RQ4 - status bit 7 reads active flag
// RQ5 - tone divides trigger by two times divider+1
// RQ6 - divider change applies to running tone
// RQ7 - decay control: mode bit7, rate bits2-0
// RQ8 - constant mode gives full non-decaying amplitude
// RQ9 - constant mode: written value sets duration only
// RQ10 - rates 0-5 update every 2^rate cycles
// RQ11 - rates 6,7 suppress all decrements
// RQ12 - software ends continuous tone by write
// RQ13 - rate change applies to running tone
// RQ14 - prescaler resets ones, divides by value+1
// RQ15 - software never writes prescaler zero
// RQ16 - each update subtracts one thirty-second
// RQ17 - stop when upper eight amplitude bits zero
// RQ18 - pwm width sets amplitude, saturating
// RQ19 - restart begins with low tone phase
// RQ20 - write-only registers read without side effect
`timescale 1ns/1ps
`default_nettype none
`include "gtg_regs.vh"
module gtg_tone_generator (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // speaker output
  output reg         tone_out
);
  // tone phase states
  localparam [1:0] PH_IDLE = 2'b00;
  localparam [1:0] PH_LOW  = 2'b01;
  localparam [1:0] PH_HIGH = 2'b10;

  // programmed registers
  reg  [7:0]  presc_ff;
  reg  [6:0]  freq_ff;
  reg  [2:0]  rate_ff;
  reg         mca_ff;

  // tone engine state
  reg         active_ff;
  reg  [12:0] amp_ff;
  reg  [1:0]  phase_ff;
  reg  [6:0]  hcnt_ff;
  reg  [4:0]  dcnt_ff;

  // next values
  reg  [12:0] nxt_amp;
  reg         nxt_active;
  reg  [1:0]  nxt_phase;
  reg  [6:0]  nxt_hcnt;
  reg  [4:0]  nxt_dcnt;
  reg  [31:0] nxt_rdata;

  // bus decode
  wire        req;
  wire        wr;
  wire        rd;
  wire        ampl_wr;
  wire        freq_wr;
  wire        decay_wr;
  wire        presc_wr;
  wire [7:0]  wr_byte;
  wire        wr_zero;

  // tone timing
  wire        trig;
  wire        pwm;
  wire        tone_high;
  wire        half_end;
  wire        cycle_end;
  wire        rate_live;
  wire        dec_evt;
  wire [12:0] dec_amp;
  wire        dec_done;
  wire [7:0]  pwm_level;

  // low dcnt bits that must all be ones before a decrement
  function [4:0] rate_mask;
    input [2:0] r;
    begin
      rate_mask = (5'h01 << r) - 5'h01;
    end
  endfunction

  // register address match, shared by the four write decodes; the read select uses its own case
  function addr_hit;
    input [3:0] adr;
    input [3:0] target;
    begin
      addr_hit = (adr == target);
    end
  endfunction

  // ack masks the request so one request gives one ack
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes need byte lane 0, other lanes carry nothing
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign rd       = req & ~wb_we_i;
  // RQ1 any amplitude write
  assign ampl_wr  = wr & addr_hit(wb_adr_i, `GTG_ADDR_AMPL);
  assign freq_wr  = wr & addr_hit(wb_adr_i, `GTG_ADDR_FREQ);
  assign decay_wr = wr & addr_hit(wb_adr_i, `GTG_ADDR_DECAY);
  assign presc_wr = wr & addr_hit(wb_adr_i, `GTG_ADDR_PRESC);

  // write data byte
  assign wr_byte  = wb_dat_i[7:0];
  assign wr_zero  = (wr_byte == 8'h00);

  // RQ14 trigger from prescaler
  // restart at the write edge, so no stale trigger follows it
  gtg_divider #(.W(8)) u_presc (
    .clk     (clk),
    .rstn    (rstn),
    .run     (active_ff),
    .restart (ampl_wr),
    .div     (presc_ff),
    .tick    (trig)
  );

  // RQ18 pwm width amplitude
  assign pwm_level = mca_ff ? 8'hff : amp_ff[12:5];
  // pwm window restarts with the tone as well
  gtg_pwm u_pwm (
    .clk     (clk),
    .rstn    (rstn),
    .run     (active_ff),
    .restart (ampl_wr),
    .trig    (trig),
    .level   (pwm_level),
    .presc   (presc_ff),
    .pwm     (pwm)
  );

  // RQ5 half period freq+1 triggers
  assign half_end  = trig & (hcnt_ff >= freq_ff);
  assign tone_high = (phase_ff == PH_HIGH);
  assign cycle_end = half_end & tone_high;
  // RQ11 rates 6 and 7 never decrement
  assign rate_live = (rate_ff <= `GTG_RATE_MAX);
  // RQ10 decrement every 2^rate cycles
  assign dec_evt   = cycle_end & rate_live &
                     ((dcnt_ff & rate_mask(rate_ff)) == rate_mask(rate_ff));
  // RQ16 subtract one thirty-second
  assign dec_amp   = amp_ff - (amp_ff >> `GTG_DECAY_SHIFT);
  // RQ17 stop when upper byte zero
  assign dec_done  = (dec_amp[12:5] == 8'h00);

  // RQ14 prescaler resets to all ones
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_ff <= `GTG_PRESC_RST;
    end else if (presc_wr) begin
      presc_ff <= wr_byte;
    end
  end

  // RQ6 live divider change
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      freq_ff <= `GTG_FREQ_RST;
    end else if (freq_wr) begin
      freq_ff <= wb_dat_i[`GTG_FREQ_MSB:0];
    end
  end

  // RQ7 mode and rate fields
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mca_ff  <= 1'b0;
      rate_ff <= `GTG_RATE_RST;
    end else if (decay_wr) begin
      mca_ff  <= wb_dat_i[`GTG_MCA_BIT];
      // RQ13 live rate change
      rate_ff <= wb_dat_i[`GTG_RATE_MSB:0];
    end
  end

  // amplitude engine
  // a write wins over a decrement in the same cycle
  always @* begin
    nxt_amp    = amp_ff;
    nxt_active = active_ff;
    if (ampl_wr) begin
      // RQ2 zero stops at once
      // RQ3 nonzero restarts with new amplitude
      nxt_amp    = {wr_byte, 5'h00};
      nxt_active = ~wr_zero;
    end else if (active_ff && dec_evt) begin
      // RQ9 decay runs in constant mode, sets duration only
      nxt_amp    = dec_amp;
      nxt_active = ~dec_done;
    end
  end

  // tone phase: low and high halves of the square wave
  always @* begin
    nxt_phase = phase_ff;
    nxt_hcnt  = hcnt_ff;
    nxt_dcnt  = dcnt_ff;
    if (ampl_wr || !nxt_active) begin
      // RQ19 restart begins with low phase
      if (nxt_active)
        nxt_phase = PH_LOW;
      else
        nxt_phase = PH_IDLE;
      nxt_hcnt  = 7'h00;
      nxt_dcnt  = 5'h00;
    end else if (trig) begin
      nxt_hcnt = half_end ? 7'h00 : hcnt_ff + 7'h01;
      if (cycle_end)
        nxt_dcnt = dcnt_ff + 5'h01;
      case (phase_ff)
        PH_LOW: begin
          if (half_end)
            nxt_phase = PH_HIGH;
        end
        PH_HIGH: begin
          if (half_end)
            nxt_phase = PH_LOW;
        end
        // idle while active cannot occur; fall back to low
        default: nxt_phase = PH_LOW;
      endcase
    end
  end

  // amplitude and flag registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      amp_ff    <= 13'h0000;
      active_ff <= 1'b0;
    end else begin
      amp_ff    <= nxt_amp;
      active_ff <= nxt_active;
    end
  end

  // phase and counter registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= PH_IDLE;
      hcnt_ff  <= 7'h00;
      dcnt_ff  <= 5'h00;
    end else begin
      phase_ff <= nxt_phase;
      hcnt_ff  <= nxt_hcnt;
      dcnt_ff  <= nxt_dcnt;
    end
  end

  // RQ8 constant mode: full pwm
  // registered so the speaker pin never glitches
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tone_out <= 1'b0;
    end else begin
      tone_out <= active_ff & tone_high & pwm;
    end
  end

  // read data select; undefined status bits read zero
  always @* begin
    nxt_rdata = 32'h00000000;
    case (wb_adr_i)
      `GTG_ADDR_AMPL: begin
        // RQ4 active flag on read
        nxt_rdata[`GTG_ACTIVE_BIT] = active_ff;
      end
      // RQ20 write-only reads zero, no effect
      `GTG_ADDR_FREQ:  nxt_rdata = 32'h00000000;
      `GTG_ADDR_DECAY: nxt_rdata = 32'h00000000;
      `GTG_ADDR_PRESC: nxt_rdata = 32'h00000000;
      default:         nxt_rdata = 32'h00000000;
    endcase
  end

  // wishbone answer: ack one cycle after the request is taken
  // unmapped addresses answer too, so a master never hangs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      // data stands with ack only, zero otherwise
      wb_dat_o <= rd ? nxt_rdata : 32'h00000000;
    end
  end
endmodule // gtg_tone_generator
`default_nettype wire

// File: tb/gtg_tone_generator_monitor.sv
// port checker for the tone generator
`timescale 1ns/1ps
`default_nettype none
module gtg_monitor (
  // watched ports
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tone_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire rdack = wb_ack_o & !wb_we_i;
  sequence s_wr;
    req & wb_we_i & wb_sel_i[0] & (wb_adr_i == 4'h0);
  endsequence
  sequence s_stop;
    s_wr ##0 (wb_dat_i[7:0] == 8'h00);
  endsequence
  sequence s_go;
    s_wr ##0 (wb_dat_i[7:0] != 8'h00);
  endsequence
  AST_ACK_NEXT: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_STATUS: assert property (rdack && wb_adr_i == 4'h0 |->
    (wb_dat_o & 32'hffffff7f) == 32'h0) else $error("status bits");
  AST_WO_READ: assert property (rdack && wb_adr_i != 4'h0 |->
    wb_dat_o == 32'h0) else $error("write-only read not zero");
  AST_STOP: assert property (s_stop |=> ##1 !tone_out [*4])
    else $error("tone not stopped");
  AST_RESTART_LOW: assert property (s_go |=> ##1 !tone_out [*2])
    else $error("restart not low");
endmodule // gtg_monitor
bind gtg_tone_generator gtg_monitor u_mon (.clk, .rstn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
  .wb_ack_o, .tone_out);
`default_nettype wire

// File: tb/gtg_speaker.sv
// speaker load model measuring tone period and high time
`timescale 1ns/1ps
`default_nettype none
module gtg_speaker (
  // clock and pin
  input  wire logic        clk,
  input  wire logic        tone_out,
  // last full tone period
  output var  logic [15:0] period,
  output var  logic [15:0] hi_width
);
  logic        prev_ff = 1'b0;
  logic [15:0] cnt_ff = 16'h0;
  logic [15:0] hi_ff = 16'h0;
  initial period = 16'h0;
  initial hi_width = 16'h0;
  // only solid high halves measured; pwm chopping splits them
  always @(posedge clk) begin
    prev_ff <= tone_out;
    cnt_ff <= cnt_ff + 16'h1;
    if (tone_out)
      hi_ff <= hi_ff + 16'h1;
    if (tone_out && !prev_ff) begin
      period <= cnt_ff;
      hi_width <= hi_ff;
      cnt_ff <= 16'h1;
      hi_ff <= 16'h1;
    end
  end
endmodule // gtg_speaker
`default_nettype wire

// File: tb/tb_gtg_tone_generator.sv
// self-checking bench for the tone generator
`timescale 1ns/1ps
`default_nettype none
module tb_gtg_tone_generator;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire         tone_out;
  wire  [15:0] period;
  wire  [15:0] hi_width;
  logic [31:0] exp_q[$];
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          seed = 53;
  logic [7:0]  amp;
  always #25 clk = ~clk;
  gtg_tone_generator dut (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .tone_out);
  gtg_speaker spk (.clk, .tone_out, .period, .hi_width);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d, logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= s;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      tally_and_finish();
    end else begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00, 4'hf);
  endtask
  // read results compared in arrival order
  always @(posedge clk)
    if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0)
      check("read data", wb_dat_o, exp_q.pop_front());
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h0, 32'h0);
    for (int a = 2; a < 16; a += 2)
      rd(a[3:0], 32'h0);
    // reset prescaler, divider and rate give one 512-cycle tone
    wr(4'h0, 8'h01);
    repeat (300) @(posedge clk);
    rd(4'h0, 32'h80);
    repeat (300) @(posedge clk);
    rd(4'h0, 32'h0);
    wr(4'hc, 8'h01);
    wr(4'h4, 8'h02);
    wr(4'h8, 8'h06);
    amp = 8'($random(seed)) | 8'h01;
    wr(4'h0, amp);
    repeat (60) @(posedge clk);
    rd(4'h0, 32'h80);
    check("period", {16'h0, period}, 32'd12);
    check("high", {16'h0, hi_width}, 32'd6);
    wr(4'h4, 8'h04);
    repeat (60) @(posedge clk);
    check("period", {16'h0, period}, 32'd20);
    bus(1'b1, 4'h0, 8'h00, 4'he);
    rd(4'h0, 32'h80);
    wr(4'h0, 8'h00);
    rd(4'h0, 32'h0);
    wr(4'h8, 8'h07);
    wr(4'h0, 8'h01);
    repeat (200) @(posedge clk);
    rd(4'h0, 32'h80);
    wr(4'h8, 8'h00);
    repeat (100) @(posedge clk);
    rd(4'h0, 32'h0);
    for (int r = 0; r < 6; r++) begin
      wr(4'h8, r[7:0]);
      wr(4'h0, 8'h01);
      rd(4'h0, 32'h80);
      repeat ((40 << r) + 40) @(posedge clk);
      rd(4'h0, 32'h0);
    end
    wr(4'hc, 8'h03);
    wr(4'h4, 8'h00);
    wr(4'h8, 8'h86);
    wr(4'h0, 8'h01);
    repeat (40) @(posedge clk);
    check("period", {16'h0, period}, 32'd8);
    check("high", {16'h0, hi_width}, 32'd4);
    tally_and_finish();
  end
endmodule // tb_gtg_tone_generator
`default_nettype wire
